// >>> sle_consts.svh
// Purpose: addresses, field positions, reset values for the link error / test config slice
// Assumes: 16-bit register addresses, 8-bit register data
// Notes:   definitions only
`ifndef SLE_CONSTS_SVH
`define SLE_CONSTS_SVH

`define SLE_LANES            8
`define SLE_ADDR_W           16
`define SLE_DATA_W           8

`define SLE_ADDR_DISP_LANES  16'h046D
`define SLE_ADDR_NIT_LANES   16'h046E
`define SLE_ADDR_UCC_LANES   16'h046F
`define SLE_ADDR_FLAGS       16'h047A
`define SLE_ADDR_SYNC_MASK   16'h047B
`define SLE_ADDR_THRESH      16'h047C
`define SLE_ADDR_LANE_ON     16'h047D
`define SLE_ADDR_RAMP        16'h047E
`define SLE_ADDR_DIG_TEST    16'h0520
`define SLE_ADDR_LEVEL_LO    16'h0521
`define SLE_ADDR_LEVEL_HI    16'h0522

`define SLE_RST_THRESH       8'hFF
`define SLE_RST_LANE_ON      8'h0F
`define SLE_RST_SYNC_MASK    8'h00
`define SLE_RST_DIG_TEST     8'h1C
`define SLE_RST_LEVEL        8'h00
`define SLE_RST_RAMP         1'b0

`define SLE_BIT_DISP         7
`define SLE_BIT_NIT          6
`define SLE_BIT_UCC          5
`define SLE_BIT_RAMP_CHECK   0
`define SLE_BIT_CONST_MODE   1

`define SLE_RAMP_LEN         2'h3
`define SLE_COUNT_MAX        8'hFF

`endif

// >>> sle_pkg.sv
// Purpose: shared types for the link error / test config slice
// Assumes: eight lanes
// Notes:   constants live in sle_consts.svh
package sle_pkg;

    // per-lane vectors of the three error kinds
    typedef struct packed {
        logic [7:0] disp;
        logic [7:0] nit;
        logic [7:0] ucc;
    } sle_err_vec_t;

    typedef struct packed {
        logic [15:0] ch1;
        logic [15:0] ch0;
    } sle_dac_pair_t;

    typedef enum logic [1:0] {
        SLE_KIND_DISP,
        SLE_KIND_NIT,
        SLE_KIND_UCC
    } sle_err_kind_t;

endpackage

// >>> sle_err_counter.sv
// Purpose: one saturating error counter for one lane and one error kind
// Assumes: event_in is a one-cycle pulse on clk_in
// Notes:   reached_out is a compare of the stored count
`timescale 1ns/1ps
`include "sle_consts.svh"

module sle_err_counter
    import sle_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       clear_in,
    input  wire logic       enable_in,
    input  wire logic       event_in,
    input  wire logic [7:0] threshold_in,
    output logic            reached_out
);

    logic [7:0] count_reg;
    logic       bump;

    assign bump = enable_in && event_in && (count_reg != `SLE_COUNT_MAX);

    // saturate so a long burst never wraps below the threshold
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= 8'h00;
        end else if (clear_in) begin
            // an error in the clear cycle still counts
            count_reg <= (enable_in && event_in) ? 8'h01 : 8'h00;
        end else if (bump) begin
            count_reg <= count_reg + 8'h01;
        end
    end

    assign reached_out = (count_reg >= threshold_in);

    ////////////////////////////////////////////////////////////////////////////
    a_count_step: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!clear_in && bump) |=> (count_reg == $past(count_reg) + 8'h01))
        else $error("error count did not step");

    a_count_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!clear_in && !enable_in) |=> $stable(count_reg))
        else $error("disabled lane counted");

endmodule

// >>> sle_link_cfg.sv
// Purpose: link error threshold, lane enables, ramp check and constant output level
// Assumes: register port and lane events are on clk_in
// Notes:   read data one cycle after the read strobe
//
// Functional notes
// - Each error kind is counted and compared to an 8-bit threshold resetting to 0xFF.
// - A count reaching the threshold raises the interrupt and/or sync request per the masks.
// - Counting runs independently on each enabled lane, comparison on every lane, both against the one threshold.
// - Lane x is enabled by bit x of the lane enable mask, which resets to 0x0F.
// - With ramp check off, alignment data content is accepted unchecked.
// - With ramp check on, alignment data must start 00-01-02 or the link fails to start.
// - The low byte of the constant level comes from its own register.
// - The high byte comes from a second register and joins the low byte into 16 bits.
// - Sync mask bits 7, 6, 5 gate disparity, invalid symbol, stray control onto sync.
// - A read-only flag per error kind shows the threshold reached on any lane.
`timescale 1ns/1ps
`include "sle_consts.svh"

module sle_link_cfg
    import sle_pkg::*;
(
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic [`SLE_ADDR_W-1:0] reg_addr_in,
    input  wire logic                   reg_wr_in,
    input  wire logic [`SLE_DATA_W-1:0] reg_wdata_in,
    input  wire logic                   reg_rd_in,
    output logic      [`SLE_DATA_W-1:0] reg_rdata_out,
    output logic                        reg_rvalid_out,
    input  wire sle_err_vec_t           lane_err_in,
    input  wire logic                   err_clear_in,
    input  wire logic [2:0]             irq_mask_in,
    output logic                        irq_out,
    output logic                        link_sync_request_out,
    output logic [7:0]                  link_lane_on_bits_out,
    input  wire logic                   ilas_start_in,
    input  wire logic                   ilas_valid_in,
    input  wire logic [7:0]             ilas_byte_in,
    output logic                        ilas_ramp_fail_out,
    output logic                        link_start_ok_out,
    input  wire sle_dac_pair_t          dac_in,
    output sle_dac_pair_t               dac_out
);

    ////////////////////////////////////////////////////////////////////////////
    // register storage
    logic [7:0]  link_error_threshold_reg;
    logic [7:0]  link_lane_on_mask_reg;
    logic [7:0]  sync_mask_reg;
    logic        alignment_ramp_check_reg;
    logic [7:0]  digital_test_ctrl_reg;
    logic [7:0]  constant_level_low_reg;
    logic [7:0]  constant_level_high_reg;
    logic [15:0] constant_output_level;
    logic        constant_output_mode;

    function automatic logic hit(input logic [`SLE_ADDR_W-1:0] a);
        hit = reg_wr_in && (reg_addr_in == a);
    endfunction

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_error_threshold_reg <= `SLE_RST_THRESH;
        end else if (hit(`SLE_ADDR_THRESH)) begin
            link_error_threshold_reg <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_lane_on_mask_reg <= `SLE_RST_LANE_ON;
        end else if (hit(`SLE_ADDR_LANE_ON)) begin
            link_lane_on_mask_reg <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_mask_reg <= `SLE_RST_SYNC_MASK;
        end else if (hit(`SLE_ADDR_SYNC_MASK)) begin
            sync_mask_reg <= {reg_wdata_in[7:5], 5'h00};
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            alignment_ramp_check_reg <= `SLE_RST_RAMP;
        end else if (hit(`SLE_ADDR_RAMP)) begin
            alignment_ramp_check_reg <= reg_wdata_in[`SLE_BIT_RAMP_CHECK];
        end
    end

    // upper field stored as written; software keeps it at default
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            digital_test_ctrl_reg <= `SLE_RST_DIG_TEST;
        end else if (hit(`SLE_ADDR_DIG_TEST)) begin
            digital_test_ctrl_reg <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            constant_level_low_reg <= `SLE_RST_LEVEL;
        end else if (hit(`SLE_ADDR_LEVEL_LO)) begin
            constant_level_low_reg <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            constant_level_high_reg <= `SLE_RST_LEVEL;
        end else if (hit(`SLE_ADDR_LEVEL_HI)) begin
            constant_level_high_reg <= reg_wdata_in;
        end
    end

    assign constant_output_level = {constant_level_high_reg, constant_level_low_reg};
    assign constant_output_mode  = digital_test_ctrl_reg[`SLE_BIT_CONST_MODE];
    assign link_lane_on_bits_out = link_lane_on_mask_reg;

    ////////////////////////////////////////////////////////////////////////////
    // per-lane error counters
    logic [7:0] disp_lanes;
    logic [7:0] nit_lanes;
    logic [7:0] ucc_lanes;
    logic [2:0] kind_flags;

    genvar g;
    generate
        for (g = 0; g < `SLE_LANES; g = g + 1) begin : g_lane
            sle_err_counter u_disp (
                .clk_in       (clk_in),
                .rst_n_in     (rst_n_in),
                .clear_in     (err_clear_in),
                .enable_in    (link_lane_on_mask_reg[g]),
                .event_in     (lane_err_in.disp[g]),
                .threshold_in (link_error_threshold_reg),
                .reached_out  (disp_lanes[g])
            );
            sle_err_counter u_nit (
                .clk_in       (clk_in),
                .rst_n_in     (rst_n_in),
                .clear_in     (err_clear_in),
                .enable_in    (link_lane_on_mask_reg[g]),
                .event_in     (lane_err_in.nit[g]),
                .threshold_in (link_error_threshold_reg),
                .reached_out  (nit_lanes[g])
            );
            sle_err_counter u_ucc (
                .clk_in       (clk_in),
                .rst_n_in     (rst_n_in),
                .clear_in     (err_clear_in),
                .enable_in    (link_lane_on_mask_reg[g]),
                .event_in     (lane_err_in.ucc[g]),
                .threshold_in (link_error_threshold_reg),
                .reached_out  (ucc_lanes[g])
            );
        end
    endgenerate

    // flag order matches bits 7..5 of the flag register
    assign kind_flags = {|disp_lanes, |nit_lanes, |ucc_lanes};

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(kind_flags & irq_mask_in);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_sync_request_out <= 1'b0;
        end else begin
            link_sync_request_out <= |(kind_flags & sync_mask_reg[7:5]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alignment ramp check, one byte stream
    logic [1:0] ramp_idx_reg;
    logic       ramp_fail_reg;
    logic       ramp_pass_reg;
    logic       ramp_match;
    logic       ramp_take;

    assign ramp_take  = ilas_valid_in && !ilas_start_in && (ramp_idx_reg != `SLE_RAMP_LEN);
    assign ramp_match = (ilas_byte_in == {6'h00, ramp_idx_reg});

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ramp_idx_reg <= 2'h0;
        end else if (ilas_start_in) begin
            ramp_idx_reg <= 2'h0;
        end else if (ramp_take) begin
            ramp_idx_reg <= ramp_idx_reg + 2'h1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ramp_fail_reg <= 1'b0;
        end else if (ilas_start_in) begin
            ramp_fail_reg <= 1'b0;
        end else if (ramp_take && !ramp_match) begin
            ramp_fail_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ramp_pass_reg <= 1'b0;
        end else if (ilas_start_in) begin
            ramp_pass_reg <= 1'b0;
        end else if (ramp_take && ramp_match && !ramp_fail_reg && (ramp_idx_reg == 2'h2)) begin
            ramp_pass_reg <= 1'b1;
        end
    end

    // check off: content ignored, startup never held back
    assign ilas_ramp_fail_out = alignment_ramp_check_reg && ramp_fail_reg;
    assign link_start_ok_out  = !alignment_ramp_check_reg || ramp_pass_reg;

    ////////////////////////////////////////////////////////////////////////////
    // DAC stream mux
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dac_out <= '0;
        end else if (constant_output_mode) begin
            dac_out <= {constant_output_level, constant_output_level};
        end else begin
            dac_out <= dac_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read back
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr_in)
            `SLE_ADDR_DISP_LANES: rd_mux = disp_lanes;
            `SLE_ADDR_NIT_LANES:  rd_mux = nit_lanes;
            `SLE_ADDR_UCC_LANES:  rd_mux = ucc_lanes;
            `SLE_ADDR_FLAGS:      rd_mux = {kind_flags, 5'h00};
            `SLE_ADDR_SYNC_MASK:  rd_mux = sync_mask_reg;
            `SLE_ADDR_THRESH:     rd_mux = link_error_threshold_reg;
            `SLE_ADDR_LANE_ON:    rd_mux = link_lane_on_mask_reg;
            `SLE_ADDR_RAMP:       rd_mux = 8'h00;
            `SLE_ADDR_DIG_TEST:   rd_mux = digital_test_ctrl_reg;
            `SLE_ADDR_LEVEL_LO:   rd_mux = constant_level_low_reg;
            `SLE_ADDR_LEVEL_HI:   rd_mux = constant_level_high_reg;
            default:              rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_mux;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_thresh_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (reg_wr_in && reg_addr_in == `SLE_ADDR_THRESH) |=>
        (link_error_threshold_reg == $past(reg_wdata_in)))
        else $error("threshold write lost");

    // built from the lane vectors and bit positions, not from the flag word
    a_sync_follows_mask: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ##1 (link_sync_request_out == ($past(disp_lanes != 8'h00 && sync_mask_reg[`SLE_BIT_DISP]) ||
                                       $past(nit_lanes != 8'h00 && sync_mask_reg[`SLE_BIT_NIT]) ||
                                       $past(ucc_lanes != 8'h00 && sync_mask_reg[`SLE_BIT_UCC]))))
        else $error("sync request not per mask");

    a_irq_follows_mask: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (|(kind_flags & irq_mask_in)) |=> irq_out)
        else $error("interrupt missed");

    a_flag_any_lane: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (reg_rd_in && reg_addr_in == `SLE_ADDR_FLAGS) |=>
        (reg_rdata_out == {$past(disp_lanes) != 8'h00, $past(nit_lanes) != 8'h00,
                           $past(ucc_lanes) != 8'h00, 5'h00}))
        else $error("error flag read back wrong");

    a_const_output: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        constant_output_mode |=> (dac_out.ch0 == $past(constant_output_level) &&
                                  dac_out.ch1 == $past(constant_output_level)))
        else $error("constant level not on both channels");

    a_ramp_bad_byte: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (alignment_ramp_check_reg && ramp_take && !ramp_match &&
         !ilas_start_in ##1 !ilas_start_in && !reg_wr_in) |-> ilas_ramp_fail_out && !link_start_ok_out)
        else $error("bad ramp accepted");

    a_ramp_off_ok: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !alignment_ramp_check_reg |-> (link_start_ok_out && !ilas_ramp_fail_out))
        else $error("ramp check off but startup held");

    a_ramp_read_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (reg_rd_in && reg_addr_in == `SLE_ADDR_RAMP) |=> (reg_rdata_out == 8'h00 && reg_rvalid_out))
        else $error("ramp register read not zero");

endmodule

// >>> sle_tx_model.sv
// Purpose: transmitter-side model feeding lane error events and alignment bytes
// Assumes: everything changes 1 ns after the rising edge of clk_in
// Notes:   a released alignment byte shows the inverse of the last one, never stale data
`timescale 1ns/1ps

module sle_tx_model
    import sle_pkg::*;
(
    input  wire logic   clk_in,
    output sle_err_vec_t lane_err_out,
    output logic        ilas_start_out,
    output logic        ilas_valid_out,
    output logic [7:0]  ilas_byte_out
);

    initial begin
        lane_err_out   = sle_err_vec_t'(24'h000000);
        ilas_start_out = 1'b0;
        ilas_valid_out = 1'b0;
        ilas_byte_out  = 8'h5A;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // n back-to-back error cycles of one kind on one lane
    task automatic send_err(input int kind, input int lane, input int n);
        logic [23:0] v;
        v = 24'h000000;
        v[(2 - kind) * 8 + lane] = 1'b1;
        repeat (n) begin
            @(posedge clk_in);
            #1;
            lane_err_out = sle_err_vec_t'(v);
        end
        @(posedge clk_in);
        #1;
        lane_err_out = sle_err_vec_t'(24'h000000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // ramp 00-01-02 after the start pulse; a bad run corrupts byte pos on purpose
    task automatic send_ilas(input bit bad, input int pos);
        logic [7:0] b;
        b = 8'h00;
        @(posedge clk_in);
        #1;
        ilas_start_out = 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_in);
            #1;
            b = (bad && i == pos) ? (8'(i) ^ 8'h40) : 8'(i);
            ilas_start_out = 1'b0;
            ilas_valid_out = 1'b1;
            ilas_byte_out  = b;
        end
        @(posedge clk_in);
        #1;
        ilas_valid_out = 1'b0;
        ilas_byte_out  = ~b;
    endtask

endmodule

// >>> testbench.sv
// Purpose: self-checking bench for the link error / test config slice
// Assumes: register strobes held one cycle, read data one cycle later
// Notes:   random lanes and thresholds from a fixed seed
`timescale 1ns/1ps
`include "sle_consts.svh"

module testbench
    import sle_pkg::*;
;
    logic          clk_in    = 1'b0;
    logic          rst_n_in  = 1'b0;
    logic [15:0]   reg_addr  = 16'h0000;
    logic          reg_wr    = 1'b0;
    logic [7:0]    reg_wdata = 8'h00;
    logic          reg_rd    = 1'b0;
    logic [7:0]    rdata;
    logic          rvalid;
    logic          err_clear = 1'b0;
    logic [2:0]    irq_mask  = 3'h0;
    logic          irq;
    logic          sync;
    logic [7:0]    lane_on;
    sle_err_vec_t  lane_err;
    logic          ilas_start;
    logic          ilas_valid;
    logic [7:0]    ilas_byte;
    logic          ramp_fail;
    logic          start_ok;
    sle_dac_pair_t dac_in_s  = sle_dac_pair_t'(32'h00000000);
    sle_dac_pair_t dac_out_s;
    int            err_count = 0;
    int            n_checks  = 0;
    int            thr;
    int            d;
    int            e;
    logic [7:0]    m;
    logic [15:0]   lvl;
    logic [15:0]   rst_addr [8] = '{`SLE_ADDR_THRESH, `SLE_ADDR_LANE_ON, `SLE_ADDR_RAMP, `SLE_ADDR_DIG_TEST,
                                    `SLE_ADDR_LEVEL_LO, `SLE_ADDR_LEVEL_HI, `SLE_ADDR_SYNC_MASK, 16'h0000};
    logic [7:0]    rst_val  [8] = '{8'hFF, 8'h0F, 8'h00, 8'h1C, 8'h00, 8'h00, 8'h00, 8'h00};

    always #2.5 clk_in = ~clk_in;

    sle_link_cfg dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr),
        .reg_wdata_in(reg_wdata), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .lane_err_in(lane_err), .err_clear_in(err_clear), .irq_mask_in(irq_mask), .irq_out(irq),
        .link_sync_request_out(sync), .link_lane_on_bits_out(lane_on), .ilas_start_in(ilas_start),
        .ilas_valid_in(ilas_valid), .ilas_byte_in(ilas_byte), .ilas_ramp_fail_out(ramp_fail),
        .link_start_ok_out(start_ok), .dac_in(dac_in_s), .dac_out(dac_out_s));

    sle_tx_model tx (.clk_in(clk_in), .lane_err_out(lane_err), .ilas_start_out(ilas_start),
        .ilas_valid_out(ilas_valid), .ilas_byte_out(ilas_byte));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] kind_flag(input int k);
        return 8'h80 >> k;
    endfunction

    // upper field kept at its default so the test path stays sane
    function automatic logic [7:0] test_ctrl(input logic mode);
        return {6'h07, mode, 1'b0};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // idle cycle after each strobe so no strobe is driven twice in one step
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        reg_addr  = a;
        reg_wdata = v;
        reg_wr    = 1'b1;
        tick(1);
        reg_wr    = 1'b0;
        tick(1);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] v, input string what);
        reg_addr = a;
        reg_rd   = 1'b1;
        tick(1);
        reg_rd   = 1'b0;
        check({31'h0, rvalid}, 32'h1, "rvalid");
        check({24'h0, rdata}, {24'h0, v}, what);
        tick(1);
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end
        else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(20000);
        err_count++;
        $display("FAIL %0t watchdog", $time);
        print_verdict();
    end

    initial begin
        void'($urandom(32'hF546));
        tick(20);
        rst_n_in = 1'b1;
        check({lane_on, 6'h0, start_ok, sync}, {8'h0F, 8'h02}, "reset outs");
        foreach (rst_addr[i]) rd_chk(rst_addr[i], rst_val[i], "reset reg");
        wr_reg(`SLE_ADDR_RAMP, 8'hFF);
        rd_chk(`SLE_ADDR_RAMP, 8'h00, "ramp read");
        wr_reg(`SLE_ADDR_SYNC_MASK, 8'hFF);
        rd_chk(`SLE_ADDR_SYNC_MASK, 8'hE0, "sync mask");
        wr_reg(16'h0000, 8'hAA);
        rd_chk(16'h0000, 8'h00, "unmapped");
        // error counting, one kind at a time, one lane off and one on
        for (int k = 0; k < 3; k++) begin
            thr = $urandom_range(5, 1);
            d = $urandom_range(7, 0);
            e = (d + 1 + $urandom_range(6, 0)) % 8;
            m = (8'($urandom) | (8'h01 << e)) & ~(8'h01 << d);
            wr_reg(`SLE_ADDR_LANE_ON, m);
            check({24'h0, lane_on}, {24'h0, m}, "lane mask");
            wr_reg(`SLE_ADDR_THRESH, 8'(thr));
            rd_chk(`SLE_ADDR_THRESH, 8'(thr), "threshold");
            wr_reg(`SLE_ADDR_SYNC_MASK, kind_flag(k));
            irq_mask = 3'h4 >> k;
            err_clear = 1'b1;
            tick(1);
            err_clear = 1'b0;
            tx.send_err(k, d, thr);
            tx.send_err(k, e, thr - 1);
            tick(3);
            rd_chk(`SLE_ADDR_FLAGS, 8'h00, "flag early");
            check({30'h0, sync, irq}, 32'h0, "outs early");
            tx.send_err(k, e, 1);
            tick(3);
            rd_chk(`SLE_ADDR_FLAGS, kind_flag(k), "flag");
            rd_chk(16'(`SLE_ADDR_DISP_LANES + k), 8'h01 << e, "lane status");
            check({30'h0, sync, irq}, 32'h3, "sync irq");
            wr_reg(`SLE_ADDR_SYNC_MASK, 8'h00);
            tick(2);
            check({30'h0, sync, irq}, 32'h1, "irq only");
            irq_mask = 3'h0;
            tick(2);
            check({31'h0, irq}, 32'h0, "irq masked");
        end
        // ramp check off, then on with a good run and each byte broken
        wr_reg(`SLE_ADDR_RAMP, 8'h00);
        tx.send_ilas(1'b1, 0);
        tick(2);
        check({30'h0, ramp_fail, start_ok}, 32'h1, "ramp off");
        wr_reg(`SLE_ADDR_RAMP, 8'h01);
        tx.send_ilas(1'b0, 0);
        tick(2);
        check({30'h0, ramp_fail, start_ok}, 32'h1, "ramp good");
        for (int p = 0; p < 3; p++) begin
            tx.send_ilas(1'b1, p);
            tick(2);
            check({30'h0, ramp_fail, start_ok}, 32'h2, "ramp bad");
        end
        // constant level, normal path then constant mode
        lvl = 16'($urandom);
        wr_reg(`SLE_ADDR_LEVEL_LO, lvl[7:0]);
        wr_reg(`SLE_ADDR_LEVEL_HI, lvl[15:8]);
        rd_chk(`SLE_ADDR_LEVEL_LO, lvl[7:0], "level lo");
        rd_chk(`SLE_ADDR_LEVEL_HI, lvl[15:8], "level hi");
        wr_reg(`SLE_ADDR_DIG_TEST, test_ctrl(1'b0));
        dac_in_s = sle_dac_pair_t'($urandom);
        tick(1);
        check(dac_out_s, dac_in_s, "dac pass");
        wr_reg(`SLE_ADDR_DIG_TEST, test_ctrl(1'b1));
        rd_chk(`SLE_ADDR_DIG_TEST, test_ctrl(1'b1), "test ctrl");
        dac_in_s = sle_dac_pair_t'($urandom);
        tick(1);
        check(dac_out_s, {lvl, lvl}, "dac const");
        print_verdict();
    end

endmodule
